// >>> include/fsp_pkg.sv
package fsp_pkg;

  // widths and counts
  localparam int unsigned XLEN       = 32;
  localparam int unsigned NUM_GPR    = 32;
  localparam int unsigned IC_INDEX_W = 11;
  localparam int unsigned STAGES     = 5;
  localparam int unsigned APB_AW     = 12;
  localparam int unsigned IMM_W      = 16;
  localparam int unsigned REG_W      = 5;
  localparam int unsigned OPC_W      = 6;

  // register map (byte addresses)
  localparam logic [APB_AW-1:0] CTRL_OFF  = 12'h000;
  localparam logic [APB_AW-1:0] EPC_OFF   = 12'h004;
  localparam logic [APB_AW-1:0] CAUSE_OFF = 12'h008;
  localparam logic [APB_AW-1:0] BOOT_OFF  = 12'h00c;

  // field positions
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_CMODE_BIT = 1;
  localparam int unsigned CTRL_W         = 2;
  localparam int unsigned CAUSE_EXL_BIT  = 0;
  localparam int unsigned CAUSE_CODE_LSB = 2;
  localparam int unsigned CAUSE_CODE_W   = 5;
  localparam int unsigned CAUSE_BD_BIT   = 31;

  // reset values and fixed codes
  localparam logic [CTRL_W-1:0]       CTRL_RESET      = 2'h0;
  localparam logic [XLEN-1:0]         BOOT_RESET      = 32'h0000_0000;
  localparam logic [CAUSE_CODE_W-1:0] TRAP_CAUSE_CODE = 5'h0d;
  localparam logic [REG_W-1:0]        LINK_REG        = 5'h1f;
  localparam logic [REG_W-1:0]        ZERO_REG        = 5'h00;
  localparam logic [XLEN-1:0]         PC_STEP         = 32'h0000_0004;
  localparam logic [XLEN-1:0]         LINK_STEP       = 32'h0000_0008;

  // instruction word fields
  localparam int unsigned OP_LSB = 26;
  localparam int unsigned RS_LSB = 21;
  localparam int unsigned RT_LSB = 16;
  localparam int unsigned RD_LSB = 11;

  typedef enum logic [OPC_W-1:0] {
    OP_NOP  = 6'h00,
    OP_ADD  = 6'h01,
    OP_JUMP_LINK_REGISTER_OP = 6'h02,
    OP_BEQ  = 6'h03,
    OP_TLT  = 6'h04,
    OP_LW   = 6'h05,
    OP_SW   = 6'h06
  } fsp_op_t;

  typedef enum logic {
    PH_FIRST  = 1'b0,
    PH_SECOND = 1'b1
  } fsp_phase_t;

  typedef struct packed {
    logic             valid;
    logic             slot;
    logic             trap;
    fsp_op_t          op;
    logic [REG_W-1:0] rs;
    logic [REG_W-1:0] rt;
    logic [REG_W-1:0] dst;
    logic [XLEN-1:0]  pc;
    logic [XLEN-1:0]  instr;
    logic [XLEN-1:0]  imm;
    logic [XLEN-1:0]  a;
    logic [XLEN-1:0]  b;
    logic [XLEN-1:0]  res;
  } fsp_stage_t;

  typedef struct packed {
    logic            rd;
    logic            wr;
    logic [XLEN-1:0] vaddr;
    logic [XLEN-1:0] wdata;
  } fsp_dreq_t;

  localparam fsp_stage_t STAGE_BUBBLE = '0;

  // fill op, register fields and sign-extended offset from the raw word
  function automatic fsp_stage_t decode_stage(input fsp_stage_t s);
    fsp_stage_t       d;
    logic [REG_W-1:0] rd;
    d     = s;
    rd    = s.instr[RD_LSB +: REG_W];
    d.rs  = s.instr[RS_LSB +: REG_W];
    d.rt  = s.instr[RT_LSB +: REG_W];
    d.imm = {{(XLEN-IMM_W){s.instr[IMM_W-1]}}, s.instr[IMM_W-1:0]};
    d.dst = ZERO_REG;
    case (s.instr[OP_LSB +: OPC_W])
      OP_ADD: begin
        d.op  = OP_ADD;
        d.dst = rd;
      end
      OP_JUMP_LINK_REGISTER_OP: begin
        d.op  = OP_JUMP_LINK_REGISTER_OP;
        d.dst = (rd == ZERO_REG) ? LINK_REG : rd;
      end
      OP_BEQ:  d.op = OP_BEQ;
      OP_TLT:  d.op = OP_TLT;
      OP_LW: begin
        d.op  = OP_LW;
        d.dst = d.rt;
      end
      OP_SW:   d.op = OP_SW;
      default: d.op = OP_NOP;
    endcase
    return d;
  endfunction

endpackage

// >>> hdl/fsp_pipe_ctrl.sv
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - five stages, each one two-phase processor_cycle
// - fetch: index and translate, then array and tag
// - operand_read_stage: decode, read two operands, target
// - execute_stage: alu, address, align, then dcache access
// - data_cache_stage align and tag; writeback writes
// - redirect reaches fetch two instructions after jump
// - compressed mode: taken branch discards following slot
// - load followed by user interlocks, never stale data
// - eleven index bits, tag versus frame, pc plus four
// - bypass picks execute, data cache or register file
// - add result latched, carried, written in writeback
// - jump_link_register_op loads pc, carries pc plus eight
// - no destination means register 31 gets link
// - branch_equal_op compares bits, adds sign-extended offset
// - branch pc valid by execute second phase
// - trap_less_than_op subtracts, sign test, kills younger
// - trap writeback loads return pc, cause, flags
// - load address is base plus sign-extended offset
// - load tag check, aligned data, written in writeback
// - store data bypassed and shifted in second phase
// - store writes dcache only on lookup hit
// - store holds dcache two cycles; memory follower slips
// - load-use detected in operand_read_stage, data forwarded
// - exception cancels itself and younger, suppresses slips
module fsp_pipe_ctrl #(
  parameter int unsigned                  TAG_W       = 20,
  parameter logic [fsp_pkg::XLEN-1:0]     TRAP_VECTOR = 32'h0000_0180
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [fsp_pkg::APB_AW-1:0]   paddr,
  input  wire logic [fsp_pkg::XLEN-1:0]     pwdata,
  output logic      [fsp_pkg::XLEN-1:0]     prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              ic_fetch,
  output logic      [fsp_pkg::XLEN-1:0]     ic_vaddr,
  output logic      [fsp_pkg::IC_INDEX_W-1:0] ic_index,
  input  wire logic [fsp_pkg::XLEN-1:0]     ic_data,
  input  wire logic [TAG_W-1:0]             ic_tag,
  input  wire logic [TAG_W-1:0]             ic_pfn,
  output fsp_pkg::fsp_dreq_t                dc_req,
  input  wire logic [fsp_pkg::XLEN-1:0]     dc_rdata,
  input  wire logic [TAG_W-1:0]             dc_tag,
  input  wire logic [TAG_W-1:0]             dc_pfn
);

  if (TAG_W < 1 || TAG_W > fsp_pkg::XLEN) begin : g_bad_tag
    $error("tag width out of range");
  end
  if (TRAP_VECTOR[1:0] != 2'h0) begin : g_bad_vector
    $error("trap vector must be word aligned");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state

  fsp_pkg::fsp_phase_t                 phase_q;
  fsp_pkg::fsp_stage_t                 rf_q;
  fsp_pkg::fsp_stage_t                 ex_q;
  fsp_pkg::fsp_stage_t                 dc_q;
  fsp_pkg::fsp_stage_t                 wb_q;
  fsp_pkg::fsp_stage_t                 if_d;
  fsp_pkg::fsp_dreq_t                  dc_req_q;
  logic [fsp_pkg::XLEN-1:0]            gpr_q [fsp_pkg::NUM_GPR];
  logic [fsp_pkg::XLEN-1:0]            pc_q;
  logic                                fetch_q;
  logic                                dc_hit_q;
  logic [fsp_pkg::CTRL_W-1:0]          ctrl_q;
  logic [fsp_pkg::XLEN-1:0]            boot_q;
  logic [fsp_pkg::XLEN-1:0]            epc_q;
  logic [fsp_pkg::CAUSE_CODE_W-1:0]    code_q;
  logic                                bd_q;
  logic                                exl_q;
  logic [fsp_pkg::XLEN-1:0]            prdata_q;
  logic                                pready_q;
  logic                                pslverr_q;

  logic                                p1;
  logic                                p2;
  logic                                run;
  logic                                cmode;
  logic                                fetch_ok;
  logic [fsp_pkg::XLEN-1:0]            op_a;
  logic [fsp_pkg::XLEN-1:0]            op_b;
  logic [fsp_pkg::XLEN-1:0]            alu_res;
  logic                                less;
  logic [fsp_pkg::XLEN-1:0]            ld_aligned;
  logic [fsp_pkg::XLEN-1:0]            dc_fwd;
  logic [fsp_pkg::XLEN-1:0]            st_aligned;
  logic                                uses_rt;
  logic                                load_use;
  logic                                store_mem;
  logic                                ex_trap;
  logic                                slip;
  logic                                hold;
  logic                                rf_ctl;
  logic                                beq_taken;
  logic                                redirect;
  logic [fsp_pkg::XLEN-1:0]            target;
  logic                                rf_we;
  logic                                ex_mem;

  assign p1    = (phase_q == fsp_pkg::PH_FIRST);
  assign p2    = (phase_q == fsp_pkg::PH_SECOND);
  assign run   = ctrl_q[fsp_pkg::CTRL_RUN_BIT];
  assign cmode = ctrl_q[fsp_pkg::CTRL_CMODE_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // phase sequencer: one processor_cycle is two pclk cycles

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= fsp_pkg::PH_FIRST;
    end else begin
      case (phase_q)
        fsp_pkg::PH_FIRST:  phase_q <= fsp_pkg::PH_SECOND;
        fsp_pkg::PH_SECOND: phase_q <= fsp_pkg::PH_FIRST;
        default:            phase_q <= fsp_pkg::PH_FIRST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fetch: index and translate in phase one, array and tag check in phase two

  assign ic_vaddr = pc_q;
  assign ic_index = pc_q[fsp_pkg::IC_INDEX_W-1:0];
  assign ic_fetch = fetch_q;
  assign fetch_ok = fetch_q && (ic_tag == ic_pfn);

  // a fetched word enters the slot if the older instruction is a jump,
  // or a branch outside compressed mode
  always_comb begin
    if_d       = fsp_pkg::STAGE_BUBBLE;
    if_d.valid = fetch_ok && !(cmode && beq_taken);
    if_d.pc    = pc_q;
    if_d.instr = ic_data;
    if_d.slot  = rf_q.valid && (rf_q.op == fsp_pkg::OP_JUMP_LINK_REGISTER_OP
                 || (rf_q.op == fsp_pkg::OP_BEQ && !cmode));
  end

  // while running, pc moves only at the stage boundary; trap beats hold (slip or slot wait) beats branch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q    <= fsp_pkg::BOOT_RESET;
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= run;
      if (!run) begin
        pc_q <= boot_q;
      end else if (p2) begin
        if (ex_trap) begin
          pc_q <= TRAP_VECTOR;
        end else if (hold) begin
          pc_q <= pc_q;
        end else if (redirect) begin
          pc_q <= target;
        end else if (fetch_ok) begin
          pc_q <= pc_q + fsp_pkg::PC_STEP;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operand read: bypass network and branch resolution

  function automatic logic [fsp_pkg::XLEN-1:0] operand(input logic [fsp_pkg::REG_W-1:0] r);
    logic [fsp_pkg::XLEN-1:0] v;
    v = gpr_q[r];
    if (r == fsp_pkg::ZERO_REG) begin
      v = '0;
    end else if (ex_q.valid && ex_q.dst == r && ex_q.op != fsp_pkg::OP_LW) begin
      v = ex_q.res;
    end else if (dc_q.valid && dc_q.dst == r) begin
      v = dc_fwd;
    end
    return v;
  endfunction

  assign op_a = operand(rf_q.rs);
  assign op_b = operand(rf_q.rt);

  assign uses_rt = (rf_q.op == fsp_pkg::OP_ADD) || (rf_q.op == fsp_pkg::OP_BEQ)
                || (rf_q.op == fsp_pkg::OP_TLT) || (rf_q.op == fsp_pkg::OP_SW);

  // load result is not ready until the end of its data cache stage
  assign load_use = rf_q.valid && ex_q.valid && ex_q.op == fsp_pkg::OP_LW
                 && ex_q.dst != fsp_pkg::ZERO_REG
                 && ((rf_q.op != fsp_pkg::OP_NOP && ex_q.dst == rf_q.rs)
                 || (uses_rt && ex_q.dst == rf_q.rt));

  // a store owns the data cache for two cycles
  assign store_mem = rf_q.valid && ex_q.valid && ex_q.op == fsp_pkg::OP_SW
                  && (rf_q.op == fsp_pkg::OP_LW || rf_q.op == fsp_pkg::OP_SW);

  assign ex_trap  = ex_q.valid && ex_q.trap;
  assign slip     = (load_use || store_mem) && !ex_trap;
  assign rf_ctl   = rf_q.valid && (rf_q.op == fsp_pkg::OP_BEQ || rf_q.op == fsp_pkg::OP_JUMP_LINK_REGISTER_OP);
  // a control op waits for its slot word so the slot is never lost on a miss
  assign hold     = slip || (rf_ctl && !fetch_ok);

  assign beq_taken = rf_q.valid && rf_q.op == fsp_pkg::OP_BEQ && !slip
                  && ((op_a ^ op_b) == '0);
  assign redirect  = beq_taken || (rf_q.valid && rf_q.op == fsp_pkg::OP_JUMP_LINK_REGISTER_OP);
  assign target    = (rf_q.op == fsp_pkg::OP_JUMP_LINK_REGISTER_OP) ? op_a
                   : rf_q.pc + rf_q.imm;

  ////////////////////////////////////////////////////////////////////////////////
  // execute and data cache datapath

  always_comb begin
    case (ex_q.op)
      fsp_pkg::OP_ADD:  alu_res = ex_q.a + ex_q.b;
      fsp_pkg::OP_TLT:  alu_res = ex_q.a - ex_q.b;
      fsp_pkg::OP_LW:   alu_res = ex_q.a + ex_q.imm;
      fsp_pkg::OP_SW:   alu_res = ex_q.a + ex_q.imm;
      fsp_pkg::OP_JUMP_LINK_REGISTER_OP: alu_res = ex_q.pc + fsp_pkg::LINK_STEP;
      default:          alu_res = ex_q.a;
    endcase
  end

  // signed less-than from the operand signs and the difference sign
  assign less = (ex_q.a[fsp_pkg::XLEN-1] != ex_q.b[fsp_pkg::XLEN-1])
              ? ex_q.a[fsp_pkg::XLEN-1] : alu_res[fsp_pkg::XLEN-1];

  assign st_aligned = ex_q.b << {ex_q.res[1:0], 3'h0};
  assign ld_aligned = dc_rdata >> {dc_q.res[1:0], 3'h0};
  assign dc_fwd     = (dc_q.op == fsp_pkg::OP_LW) ? ld_aligned : dc_q.res;
  assign ex_mem     = ex_q.valid && (ex_q.op == fsp_pkg::OP_LW || ex_q.op == fsp_pkg::OP_SW);

  ////////////////////////////////////////////////////////////////////////////////
  // stage registers: phase one does in-stage work, phase two advances

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_q     <= fsp_pkg::STAGE_BUBBLE;
      ex_q     <= fsp_pkg::STAGE_BUBBLE;
      dc_q     <= fsp_pkg::STAGE_BUBBLE;
      wb_q     <= fsp_pkg::STAGE_BUBBLE;
      dc_hit_q <= 1'b0;
    end else if (p1) begin
      rf_q     <= fsp_pkg::decode_stage(rf_q);
      ex_q.res <= alu_res;
      ex_q.trap <= ex_q.valid && ex_q.op == fsp_pkg::OP_TLT && less;
      dc_hit_q <= dc_q.valid && (dc_tag == dc_pfn);
    end else begin
      // back end never waits for the front
      wb_q <= dc_q;
      if (dc_q.op == fsp_pkg::OP_LW) begin
        wb_q.res <= ld_aligned;
      end
      dc_q   <= ex_q;
      dc_q.b <= st_aligned;
      if (ex_trap || hold) begin
        ex_q <= fsp_pkg::STAGE_BUBBLE;
      end else begin
        ex_q   <= rf_q;
        ex_q.a <= op_a;
        ex_q.b <= op_b;
      end
      if (ex_trap) begin
        rf_q <= fsp_pkg::STAGE_BUBBLE;
      end else if (!hold) begin
        rf_q <= if_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data cache port: reads in execute phase two, store writes in writeback phase one

  assign dc_req = dc_req_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_req_q <= '0;
    end else if (p1) begin
      dc_req_q.rd    <= ex_mem;
      dc_req_q.wr    <= 1'b0;
      dc_req_q.vaddr <= alu_res;
      dc_req_q.wdata <= '0;
    end else begin
      dc_req_q.rd    <= 1'b0;
      dc_req_q.wr    <= dc_q.valid && dc_q.op == fsp_pkg::OP_SW && dc_hit_q;
      dc_req_q.vaddr <= dc_q.res;
      dc_req_q.wdata <= dc_q.b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file: written in writeback phase one, read later in the same cycle

  assign rf_we = p1 && wb_q.valid && !wb_q.trap && wb_q.dst != fsp_pkg::ZERO_REG;

  for (genvar g = 0; g < fsp_pkg::NUM_GPR; g++) begin : g_gpr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gpr_q[g] <= '0;
      end else if (rf_we && wb_q.dst == fsp_pkg::REG_W'(g)) begin
        gpr_q[g] <= wb_q.res;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // exception state; a trap arriving with a software clear keeps the level bit set

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epc_q  <= '0;
      code_q <= '0;
      bd_q   <= 1'b0;
      exl_q  <= 1'b0;
    end else if (p1 && wb_q.valid && wb_q.trap) begin
      epc_q  <= wb_q.slot ? wb_q.pc - fsp_pkg::PC_STEP : wb_q.pc;
      code_q <= fsp_pkg::TRAP_CAUSE_CODE;
      bd_q   <= wb_q.slot;
      exl_q  <= 1'b1;
    end else if (psel && penable && pwrite && pready_q && paddr == fsp_pkg::CAUSE_OFF
                 && pwdata[fsp_pkg::CAUSE_EXL_BIT]) begin
      exl_q  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, write lands on the completing edge

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= fsp_pkg::CTRL_RESET;
      boot_q <= fsp_pkg::BOOT_RESET;
    end else if (psel && penable && pwrite && pready_q) begin
      case (paddr)
        fsp_pkg::CTRL_OFF: ctrl_q <= pwdata[fsp_pkg::CTRL_W-1:0];
        fsp_pkg::BOOT_OFF: boot_q <= pwdata;
        default:           ctrl_q <= ctrl_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
      if (psel && penable && !pready_q) begin
        case (paddr)
          fsp_pkg::CTRL_OFF:  prdata_q <= {{(fsp_pkg::XLEN-fsp_pkg::CTRL_W){1'b0}}, ctrl_q};
          fsp_pkg::EPC_OFF:   prdata_q <= epc_q;
          fsp_pkg::CAUSE_OFF: begin
            prdata_q[fsp_pkg::CAUSE_BD_BIT]                              <= bd_q;
            prdata_q[fsp_pkg::CAUSE_CODE_LSB +: fsp_pkg::CAUSE_CODE_W] <= code_q;
            prdata_q[fsp_pkg::CAUSE_EXL_BIT]                             <= exl_q;
          end
          fsp_pkg::BOOT_OFF:  prdata_q <= boot_q;
          default:            pslverr_q <= 1'b1;
        endcase
      end
    end
  end

endmodule

// >>> dv/fsp_pipe_ctrl_properties.sv
`timescale 1ns/1ps

// watches the apb answer and the cache strobes at the pipeline's ports
module fsp_pipe_checker (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic [fsp_pkg::XLEN-1:0]       prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  input wire logic [fsp_pkg::XLEN-1:0]       ic_vaddr,
  input wire logic [fsp_pkg::IC_INDEX_W-1:0] ic_index,
  input wire fsp_pkg::fsp_dreq_t             dc_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // a store looks up in execute phase two and writes three clocks later
  sequence s_store;
    dc_req.rd ##3 dc_req.wr;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait");
  ready_once_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  err_quiet_a: assert property (pslverr |-> pready && prdata == '0)
    else $error("error answer without ready or with data");
  idle_data_a: assert property (!pready |-> prdata == '0)
    else $error("read data shown outside an answer");
  index_low_a: assert property (ic_index == ic_vaddr[10:0])
    else $error("icache index is not the low address bits");
  rd_pulse_a: assert property (dc_req.rd |=> !dc_req.rd)
    else $error("dcache lookup longer than one clock");
  wr_source_a: assert property (dc_req.wr |-> $past(dc_req.rd, 3))
    else $error("dcache write without lookup three clocks before");
  store_addr_a: assert property (s_store |-> dc_req.vaddr == $past(dc_req.vaddr, 3))
    else $error("store writes another address than it looked up");
  store_slip_a: assert property (s_store |-> !$past(dc_req.rd, 1))
    else $error("memory follower not slipped behind a store");
  reset_quiet_a: assert property ($rose(presetn) |-> dc_req == '0 && !pready)
    else $error("outputs not idle after reset release");
endmodule

// >>> dv/fsp_mem_model.sv
`timescale 1ns/1ps

// instruction and data cache stand-in; always hits on data, slow mode misses fetches
module fsp_mem_model (
  input  wire logic                      pclk,
  input  wire logic                      slow,
  input  wire logic [fsp_pkg::XLEN-1:0]  ic_vaddr,
  output logic      [fsp_pkg::XLEN-1:0]  ic_data,
  output logic      [19:0]               ic_tag,
  output logic      [19:0]               ic_pfn,
  input  wire fsp_pkg::fsp_dreq_t        dc_req,
  output logic      [fsp_pkg::XLEN-1:0]  dc_rdata,
  output logic      [19:0]               dc_tag,
  output logic      [19:0]               dc_pfn
);
  logic [31:0] imem [64];
  logic [31:0] dmem [16];
  logic [31:0] addr_q = 32'h0000_0000;
  logic [1:0]  hold_q = 2'h0;
  logic [1:0]  miss_q = 2'h0;

  // period three so misses fall on fetch sampling edges too
  always @(posedge pclk) begin
    miss_q <= (miss_q == 2'h2) ? 2'h0 : miss_q + 2'h1;
    hold_q <= dc_req.rd ? 2'h3 : ((hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0);
    if (dc_req.rd) begin
      addr_q <= dc_req.vaddr;
    end
    if (dc_req.wr) begin
      dmem[dc_req.vaddr[5:2]] <= dc_req.wdata;
    end
  end

  // data is only good while held; otherwise inverted so stale reads show
  assign ic_data  = imem[ic_vaddr[7:2]];
  assign ic_pfn   = 20'h2a5c3;
  assign ic_tag   = (slow && miss_q == 2'h0) ? 20'h00000 : 20'h2a5c3;
  assign dc_pfn   = 20'h15e07;
  assign dc_tag   = 20'h15e07;
  assign dc_rdata = (hold_q != 2'h0) ? dmem[addr_q[5:2]] : ~dmem[addr_q[5:2]];
endmodule

// >>> dv/test_five_stage_pipeline_control.sv
`timescale 1ns/1ps

// drives the pipeline through apb and judges registers and memory effects
module test_five_stage_pipeline_control;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic               slow = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [31:0]        prdata, ic_vaddr, ic_data, dc_rdata, rd_v;
  logic               pready, pslverr, ic_fetch, err_v;
  logic [10:0]        ic_index;
  logic [19:0]        ic_tag, ic_pfn, dc_tag, dc_pfn;
  fsp_pkg::fsp_dreq_t dc_req;
  int                 n_fail = 0;
  int                 checks = 0;
  int                 cyc = 0;

  fsp_pipe_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ic_fetch, .ic_vaddr, .ic_index, .ic_data, .ic_tag, .ic_pfn,
    .dc_req, .dc_rdata, .dc_tag, .dc_pfn);
  fsp_mem_model mdl (.pclk, .slow, .ic_vaddr, .ic_data, .ic_tag, .ic_pfn, .dc_req,
    .dc_rdata, .dc_tag, .dc_pfn);

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock; the ceiling is far above two program runs
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic put(input logic [7:0] a, input logic [5:0] op, input logic [4:0] s,
                     input logic [4:0] t, input logic [15:0] im);
    mdl.imem[a[7:2]] = {op, s, t, im};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped access, read-only return pc, boot address
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0000_0000, rd_v, err_v);
      chk(rd_v, 32'h0000_0000);
    end
    apb(1'b0, 12'h010, 32'h0000_0000, rd_v, err_v);
    chk({rd_v[30:0], err_v}, 32'h0000_0001);
    apb(1'b1, fsp_pkg::EPC_OFF, 32'hffff_fffc, rd_v, err_v);
    apb(1'b0, fsp_pkg::EPC_OFF, 32'h0000_0000, rd_v, err_v);
    chk(rd_v, 32'h0000_0000);
    apb(1'b1, fsp_pkg::BOOT_OFF, 32'h0000_0100, rd_v, err_v);
    apb(1'b0, fsp_pkg::BOOT_OFF, 32'h0000_0000, rd_v, err_v);
    chk(rd_v, 32'h0000_0100);
  endtask

  // runs the program until the trap, then judges memory and exception state
  task automatic t_prog(input logic cm, input logic sl);
    logic [31:0] want [10];
    want = '{32'h140, 32'h0, 32'h280, 32'h280, 32'h280, 32'h0, 32'h11c,
             cm ? 32'h0 : 32'h280, 32'h0, 32'h0};
    // fresh reset, so registers left by a former run cannot mask a broken bypass
    @(posedge pclk);
    presetn <= 1'b0;
    slow    <= sl;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) mdl.dmem[i] = (i == 0) ? 32'h0000_0140 : 32'h0000_0000;
    apb(1'b1, fsp_pkg::BOOT_OFF, 32'h0000_0100, rd_v, err_v);
    chk({31'h0, ic_fetch}, 32'h0000_0000);
    apb(1'b1, fsp_pkg::CTRL_OFF, {30'h0, cm, 1'b1}, rd_v, err_v);
    rd_v = 32'h0000_0000;
    for (int i = 0; i < 200 && rd_v[0] !== 1'b1; i++) begin
      apb(1'b0, fsp_pkg::CAUSE_OFF, 32'h0000_0000, rd_v, err_v);
    end
    chk(rd_v, 32'h0000_0035);
    chk({31'h0, ic_fetch}, 32'h0000_0001);
    apb(1'b0, fsp_pkg::EPC_OFF, 32'h0000_0000, rd_v, err_v);
    chk(rd_v, 32'h0000_0154);
    for (int i = 0; i < 10; i++) chk(mdl.dmem[i], want[i]);
    apb(1'b1, fsp_pkg::CTRL_OFF, 32'h0000_0000, rd_v, err_v);
    apb(1'b1, fsp_pkg::CAUSE_OFF, 32'h0000_0001, rd_v, err_v);
    apb(1'b0, fsp_pkg::CAUSE_OFF, 32'h0000_0000, rd_v, err_v);
    chk(rd_v, 32'h0000_0034);
    chk({31'h0, ic_fetch}, 32'h0000_0000);
  endtask

  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // load-use, store slips, jump with link, branch slot and a trap at 0x154
  initial begin
    for (int i = 0; i < 64; i++) mdl.imem[i] = 32'h0000_0000;
    put(8'h00, 6'h05, 5'h00, 5'h01, 16'h0000);
    put(8'h04, 6'h01, 5'h01, 5'h01, 16'h1000);
    put(8'h08, 6'h06, 5'h00, 5'h02, 16'h0008);
    put(8'h0c, 6'h05, 5'h00, 5'h03, 16'h0008);
    put(8'h10, 6'h06, 5'h00, 5'h03, 16'h000c);
    put(8'h14, 6'h02, 5'h01, 5'h00, 16'h0000);
    put(8'h18, 6'h06, 5'h00, 5'h02, 16'h0010);
    put(8'h1c, 6'h06, 5'h00, 5'h02, 16'h0014);
    put(8'h40, 6'h06, 5'h00, 5'h1f, 16'h0018);
    put(8'h44, 6'h03, 5'h00, 5'h00, 16'h0010);
    put(8'h48, 6'h06, 5'h00, 5'h02, 16'h001c);
    put(8'h4c, 6'h06, 5'h00, 5'h02, 16'h0020);
    put(8'h54, 6'h04, 5'h00, 5'h01, 16'h0000);
    put(8'h58, 6'h06, 5'h00, 5'h02, 16'h0024);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_prog(1'b0, 1'b0);
    t_prog(1'b1, 1'b1);
    end_sim();
  end
endmodule

bind fsp_pipe_ctrl fsp_pipe_checker chk_i (.pclk, .presetn, .psel, .penable, .prdata,
  .pready, .pslverr, .ic_vaddr, .ic_index, .dc_req);
